/* pwr_sequencer.sv */
// Power, reset, low-power mode and wake-up sequencer.
// Assumes all inputs synchronous to clk_i; analog comparators outside.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_regs.svh"
module pwr_sequencer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic supply_low_i,
  input wire logic supply_below_thr_i,
  input wire logic supply_det_en_i,
  input wire logic supply_det_fall_en_i,
  input wire logic supply_det_rise_en_i,
  input wire logic external_reset_pin_i,
  input wire logic independent_watchdog_rst_i,
  input wire logic wakeup_pin_i,
  input wire logic rtc_alarm_i,
  input wire logic usb_wake_i,
  input wire logic [1:0] boot_pins_i,
  input wire logic [79:0] gpio_i,
  input wire logic [79:0] gpio_pulse_i,
  input wire logic [111:0] line_sel_i,
  input wire pwr_pkg::pwr_line_cfg_t line_cfg_i,
  input wire logic [18:0] pend_clr_i,
  input wire logic [1:0] clk_sel_i,
  input wire logic efo_fail_i,
  input wire logic efo_fail_clr_i,
  input wire logic sleep_req_i,
  input wire logic stop_req_i,
  input wire logic stop_lp_reg_i,
  input wire logic standby_req_i,
  input wire logic periph_irq_i,
  output logic core_rst_o,
  output logic [1:0] boot_sel_o,
  output logic [1:0] cpu_clk_src_o,
  output logic efo_fail_irq_o,
  output logic supply_det_irq_o,
  output pwr_pkg::pwr_reg_mode_t reg_mode_o,
  output pwr_pkg::pwr_clk_ctl_t clk_ctl_o,
  output logic rtc_wdg_run_o,
  output logic [18:0] line_pend_o,
  output logic [18:0] line_req_o,
  output pwr_pkg::pwr_state_t state_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Edge event lines
  logic [15:0] ext_line;
  logic [15:0] ext_pulse;
  logic [18:0] all_line;
  logic [18:0] all_pulse;
  logic supply_det_out;

  pwr_pin_mux u_line_mux (
    .pin_i(gpio_i),
    .sel_i(line_sel_i),
    .line_o(ext_line)
  );

  pwr_pin_mux u_pulse_mux (
    .pin_i(gpio_pulse_i),
    .sel_i(line_sel_i),
    .line_o(ext_pulse)
  );

  // Internal sources on lines 16 to 18
  assign supply_det_out = supply_det_en_i & supply_below_thr_i;
  assign all_line = {usb_wake_i, rtc_alarm_i, supply_det_out, ext_line};
  assign all_pulse = {3'h0, ext_pulse};

  pwr_edge_unit u_edges (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .line_i(all_line),
    .pulse_i(all_pulse),
    .cfg_i(line_cfg_i),
    .pend_clr_i(pend_clr_i),
    .pend_o(line_pend_o),
    .req_o(line_req_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset hold and restart
  logic rst_cause;
  logic wake_last_q;
  logic wake_rise;
  logic standby_wake;
  pwr_pkg::pwr_state_t state_q;

  assign wake_rise = wakeup_pin_i & ~wake_last_q;
  assign standby_wake = external_reset_pin_i | independent_watchdog_rst_i
                      | wake_rise | rtc_alarm_i;
  assign rst_cause = supply_low_i | external_reset_pin_i | independent_watchdog_rst_i;

  // Wake pin edge history
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_last_q <= 1'b0;
    end else begin
      wake_last_q <= wakeup_pin_i;
    end
  end

  assign core_rst_o = (state_q == pwr_pkg::PWR_ST_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= pwr_pkg::PWR_ST_RESET;
    end else if (rst_cause) begin
      state_q <= pwr_pkg::PWR_ST_RESET;
    end else begin
      case (state_q)
        pwr_pkg::PWR_ST_RESET: begin
          state_q <= pwr_pkg::PWR_ST_RUN;
        end
        pwr_pkg::PWR_ST_RUN: begin
          if (standby_req_i) begin
            state_q <= pwr_pkg::PWR_ST_STANDBY;
          end else if (stop_req_i) begin
            state_q <= pwr_pkg::PWR_ST_STOP;
          end else if (sleep_req_i) begin
            state_q <= pwr_pkg::PWR_ST_SLEEP;
          end
        end
        pwr_pkg::PWR_ST_SLEEP: begin
          if (periph_irq_i || (line_req_o != 19'h00000)) begin
            state_q <= pwr_pkg::PWR_ST_RUN;
          end
        end
        pwr_pkg::PWR_ST_STOP: begin
          if (line_req_o != 19'h00000) begin
            state_q <= pwr_pkg::PWR_ST_RUN;
          end
        end
        pwr_pkg::PWR_ST_STANDBY: begin
          if (standby_wake) begin
            state_q <= pwr_pkg::PWR_ST_RESET;
          end
        end
        default: begin
          state_q <= pwr_pkg::PWR_ST_RESET;
        end
      endcase
    end
  end

  assign state_o = state_q;

  ////////////////////////////////////////////////////////////////////////////
  // Boot pin capture during the reset state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      boot_sel_o <= `PWR_BOOT_FLASH;
    end else if (state_q == pwr_pkg::PWR_ST_RESET) begin
      if (boot_pins_i[0] == 1'b0) begin
        boot_sel_o <= `PWR_BOOT_FLASH;
      end else if (boot_pins_i[1] == 1'b0) begin
        boot_sel_o <= `PWR_BOOT_SYSMEM;
      end else begin
        boot_sel_o <= `PWR_BOOT_SRAM;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock source and external oscillator failure
  logic efo_dead_q;

  // Failure only matters while an external-derived source drives the CPU
  function automatic logic efo_lost(input logic fail, input logic [1:0] src);
    return fail && (src != `PWR_CLK_IFO);
  endfunction : efo_lost

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      efo_dead_q <= 1'b0;
    end else if (state_q == pwr_pkg::PWR_ST_RESET) begin
      efo_dead_q <= 1'b0;
    end else if (efo_lost(efo_fail_i, cpu_clk_src_o)) begin
      efo_dead_q <= 1'b1;
    end
  end

  // Failure flag; detection wins over software clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      efo_fail_irq_o <= 1'b0;
    end else if (efo_lost(efo_fail_i, cpu_clk_src_o)) begin
      efo_fail_irq_o <= 1'b1;
    end else if (efo_fail_clr_i) begin
      efo_fail_irq_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cpu_clk_src_o <= `PWR_CLK_IFO;
    end else if (state_q == pwr_pkg::PWR_ST_RESET) begin
      cpu_clk_src_o <= `PWR_CLK_IFO;
    end else if (efo_lost(efo_fail_i, cpu_clk_src_o)) begin
      cpu_clk_src_o <= `PWR_CLK_IFO;
    end else if (state_q == pwr_pkg::PWR_ST_RUN && !efo_dead_q) begin
      cpu_clk_src_o <= clk_sel_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply threshold detector interrupt
  logic below_last_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      below_last_q <= 1'b0;
    end else begin
      below_last_q <= supply_below_thr_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      supply_det_irq_o <= 1'b0;
    end else begin
      supply_det_irq_o <= supply_det_en_i & (
          (supply_det_fall_en_i & supply_below_thr_i & ~below_last_q)
        | (supply_det_rise_en_i & ~supply_below_thr_i & below_last_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator mode and clock gating per state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_mode_o <= pwr_pkg::PWR_REG_MAIN;
    end else begin
      case (state_q)
        pwr_pkg::PWR_ST_STOP: begin
          reg_mode_o <= stop_lp_reg_i ? pwr_pkg::PWR_REG_LOW
                                      : pwr_pkg::PWR_REG_MAIN;
        end
        pwr_pkg::PWR_ST_STANDBY: begin
          reg_mode_o <= pwr_pkg::PWR_REG_OFF;
        end
        default: begin
          reg_mode_o <= pwr_pkg::PWR_REG_MAIN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_ctl_o <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    end else begin
      case (state_q)
        pwr_pkg::PWR_ST_SLEEP: begin
          clk_ctl_o <= '{1'b0, 1'b1, clk_ctl_o.pll_en, 1'b1,
                         clk_ctl_o.efo_en, 1'b1};
        end
        pwr_pkg::PWR_ST_STOP: begin
          clk_ctl_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        end
        pwr_pkg::PWR_ST_STANDBY: begin
          clk_ctl_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        end
        default: begin
          clk_ctl_o <= '{1'b1, 1'b1, cpu_clk_src_o == `PWR_CLK_PLL, 1'b1,
                         (cpu_clk_src_o != `PWR_CLK_IFO) && !efo_dead_q, 1'b1};
        end
      endcase
    end
  end

  // Low-speed domain never gated by mode
  assign rtc_wdg_run_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_stop_wake;
    (state_q == pwr_pkg::PWR_ST_STOP) && (line_req_o != 19'h00000) && !rst_cause;
  endsequence

  // Stop entry from run, then the oscillator gating that must follow it
  sequence s_stop_entry;
    (state_q == pwr_pkg::PWR_ST_RUN) && stop_req_i && !standby_req_i && !rst_cause;
  endsequence

  sequence s_stop_gated;
    (state_q == pwr_pkg::PWR_ST_STOP) ##1 !(clk_ctl_o.cpu_clk_en || clk_ctl_o.pll_en
      || clk_ctl_o.ifo_en || clk_ctl_o.efo_en);
  endsequence

  chk_reset_clock_default: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == pwr_pkg::PWR_ST_RESET) |=> (cpu_clk_src_o == `PWR_CLK_IFO))
    else $error("reset did not select internal oscillator");
  chk_efo_fail_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (efo_fail_i && cpu_clk_src_o != `PWR_CLK_IFO) |=> efo_fail_irq_o
      && cpu_clk_src_o == `PWR_CLK_IFO)
    else $error("clock failure not handled");
  chk_supply_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    supply_low_i |=> core_rst_o)
    else $error("low supply did not hold reset");
  chk_standby_regulator: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == pwr_pkg::PWR_ST_STANDBY) |=> (reg_mode_o == pwr_pkg::PWR_REG_OFF))
    else $error("regulator on in standby");
  chk_stop_clocks_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == pwr_pkg::PWR_ST_STOP) |=> !clk_ctl_o.core_clk_en && clk_ctl_o.retain)
    else $error("stop mode clocks not gated");
  chk_stop_entry_gates: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_stop_entry |=> s_stop_gated)
    else $error("stop entry left oscillators running");
  chk_stop_wake_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_stop_wake |=> (state_q == pwr_pkg::PWR_ST_RUN))
    else $error("edge line did not wake from stop");
  chk_standby_no_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == pwr_pkg::PWR_ST_STANDBY) && !standby_wake && !supply_low_i
      |=> (state_q == pwr_pkg::PWR_ST_STANDBY))
    else $error("standby left without a wake cause");
  chk_standby_exit_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == pwr_pkg::PWR_ST_STANDBY && standby_wake) |=>
      (state_q == pwr_pkg::PWR_ST_RESET) ##1 (state_q != pwr_pkg::PWR_ST_STANDBY))
    else $error("standby exit skipped reset");
  chk_sleep_cpu_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == pwr_pkg::PWR_ST_SLEEP) |=> !clk_ctl_o.cpu_clk_en && clk_ctl_o.core_clk_en)
    else $error("sleep gated more than the cpu");
  chk_supply_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    supply_det_irq_o |-> $past(supply_det_en_i))
    else $error("detector interrupt while disabled");
endmodule : pwr_sequencer
`default_nettype wire

/* pwr_regs.svh */
// Constants for the power and wake-up sequencer.
// Assumes inclusion by bare name; no processes here.
`ifndef PWR_REGS_SVH
`define PWR_REGS_SVH
`define PWR_LINES 19
`define PWR_EXT_LINES 16
`define PWR_PIN_COUNT 80
`define PWR_PIN_SEL_W 7
`define PWR_LINE_SUPPLY 16
`define PWR_LINE_RTC 17
`define PWR_LINE_USB 18
`define PWR_CLK_MHZ 40
`define PWR_IFO_MHZ 8
`define PWR_WAKE_NS 100
`define PWR_WAKE_CYC (((`PWR_WAKE_NS * `PWR_CLK_MHZ) + 999) / 1000)
`define PWR_BUS_MAX_MHZ 72
`define PWR_LOW_BUS_MAX_MHZ 36
`define PWR_CLK_IFO 2'h0
`define PWR_CLK_EFO 2'h1
`define PWR_CLK_PLL 2'h2
`define PWR_BOOT_FLASH 2'h0
`define PWR_BOOT_SYSMEM 2'h1
`define PWR_BOOT_SRAM 2'h3
`endif

/* pwr_pkg.sv */
// Types for the power and wake-up sequencer.
// Assumes pwr_regs.svh is on the include path.
package pwr_pkg;
  typedef enum logic [1:0] {
    PWR_REG_MAIN, PWR_REG_LOW, PWR_REG_OFF
  } pwr_reg_mode_t;
  typedef enum logic [2:0] {
    PWR_ST_RESET, PWR_ST_RUN, PWR_ST_SLEEP, PWR_ST_STOP, PWR_ST_STANDBY
  } pwr_state_t;
  typedef struct packed {
    logic [18:0] rise;
    logic [18:0] fall;
    logic [18:0] mask;
  } pwr_line_cfg_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic pll_en;
    logic ifo_en;
    logic efo_en;
    logic retain;
  } pwr_clk_ctl_t;
endpackage : pwr_pkg

/* pwr_edge_unit.sv */
// Edge event unit: nineteen lines with edge select, mask and pending.
// Assumes line inputs synchronous; narrow pulses caught by latch path.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_regs.svh"
module pwr_edge_unit (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [18:0] line_i,
  input wire logic [18:0] pulse_i,
  input wire pwr_pkg::pwr_line_cfg_t cfg_i,
  input wire logic [18:0] pend_clr_i,
  output logic [18:0] pend_o,
  output logic [18:0] req_o
);
  logic [18:0] last_q;
  logic [18:0] pend_q;
  logic [18:0] hit;

  // Edge test per line; pulse_i flags a sub-period pulse seen asynchronously
  always_comb begin
    hit = (cfg_i.rise & line_i & ~last_q)
        | (cfg_i.fall & ~line_i & last_q)
        | (pulse_i & (cfg_i.rise | cfg_i.fall));
  end

  // Previous level per line
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_q <= 19'h00000;
    end else begin
      last_q <= line_i;
    end
  end

  // Pending flags; a new hit beats a clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= 19'h00000;
    end else begin
      pend_q <= (pend_q & ~pend_clr_i) | (hit & ~cfg_i.mask);
    end
  end

  assign pend_o = pend_q;
  assign req_o = hit & ~cfg_i.mask;

  // Masked lines neither request nor gain a pending flag
  chk_masked_line_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ((req_o & cfg_i.mask) == 19'h00000)
      && ((pend_o & ~$past(pend_o) & $past(cfg_i.mask)) == 19'h00000))
    else $error("masked line raised a request");
  chk_pending_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (req_o != 19'h00000) |=> ((pend_o & $past(req_o)) == $past(req_o)))
    else $error("request left no pending flag");
endmodule : pwr_edge_unit
`default_nettype wire

/* pwr_pin_mux.sv */
// Pin selector feeding the sixteen external lines from eighty pins.
// Assumes pin inputs synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_regs.svh"
module pwr_pin_mux (
  input wire logic [79:0] pin_i,
  input wire logic [111:0] sel_i,
  output logic [15:0] line_o
);
  // Each line picks one pin by its seven-bit index
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      line_o[i] = (sel_i[i*7 +: 7] < 7'h50) ? pin_i[sel_i[i*7 +: 7]] : 1'b0;
    end
  end
endmodule : pwr_pin_mux
`default_nettype wire

/* pwr_far_model.sv */
// Far-side model: pins, boot straps, wake sources and reset causes.
// Assumes every change is made just after a rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module pwr_far_model (
  input wire logic clk_i,
  output var logic [79:0] gpio_o,
  output var logic [79:0] pulse_o,
  output var logic [8:0] misc_o,
  output var logic [1:0] boot_o
);
  // Extra cycles before a change, for slow answers
  int lag = 0;
  // Idle levels at power-up
  initial begin
    gpio_o = 80'h0;
    pulse_o = 80'h0;
    misc_o = 9'h000;
    boot_o = 2'h0;
  end
  // Pin level change
  task automatic set_pin(input int p, input logic v);
    repeat (lag) @(posedge clk_i);
    @(posedge clk_i);
    gpio_o[p] <= v;
  endtask : set_pin
  // Narrow pulse flag, held until clr_pulse
  task automatic pulse_pin(input int p);
    @(posedge clk_i);
    pulse_o[p] <= 1'b1;
  endtask : pulse_pin
  task automatic clr_pulse();
    pulse_o <= 80'h0;
  endtask : clr_pulse
  // Wake sources and reset causes move only on request
  task automatic set_misc(input int b, input logic v);
    repeat (lag) @(posedge clk_i);
    @(posedge clk_i);
    misc_o[b] <= v;
  endtask : set_misc
  task automatic set_boot(input logic [1:0] b);
    @(posedge clk_i);
    boot_o <= b;
  endtask : set_boot
endmodule : pwr_far_model
`default_nettype wire

/* test_power_modes_and_wake_events.sv */
// Testbench for the power and wake-up sequencer.
// Assumes pwr_pkg compiled first; far side from pwr_far_model.
`timescale 1ns/1ps
`default_nettype none
module test_power_modes_and_wake_events;
  logic clk_i, sys_rst_i, supply_det_en_i, supply_det_fall_en_i, supply_det_rise_en_i;
  logic efo_fail_clr_i, sleep_req_i, stop_req_i, stop_lp_reg_i, standby_req_i;
  logic [111:0] line_sel_i;
  pwr_pkg::pwr_line_cfg_t line_cfg_i;
  logic [18:0] pend_clr_i, line_pend_o, line_req_o, expv;
  logic [1:0] clk_sel_i, boot_sel_o, cpu_clk_src_o;
  logic core_rst_o, efo_fail_irq_o, supply_det_irq_o, rtc_wdg_run_o, msk, usep, lvl;
  pwr_pkg::pwr_reg_mode_t reg_mode_o;
  pwr_pkg::pwr_clk_ctl_t clk_ctl_o;
  pwr_pkg::pwr_state_t state_o;
  wire logic [79:0] gpio_i, gpio_pulse_i;
  wire logic [8:0] misc;
  wire logic [1:0] boot_pins_i;
  int err_count = 0;
  int total_checks = 0;
  int ln, pin, md, cnt;
  logic [31:0] seed = 32'h00000044;
  int cause[4] = '{3, 4, 0, 1};
  logic [4:0] sup_tab[6] = '{5'h1B, 5'h18, 5'h16, 5'h15, 5'h0E, 5'h0C};

  ////////////////////////////////////////////////////////////////////////////
  pwr_far_model far (.clk_i, .gpio_o(gpio_i), .pulse_o(gpio_pulse_i), .misc_o(misc),
    .boot_o(boot_pins_i));
  pwr_sequencer DUT (
    .clk_i, .sys_rst_i, .supply_low_i(misc[6]), .supply_below_thr_i(misc[7]),
    .supply_det_en_i, .supply_det_fall_en_i, .supply_det_rise_en_i,
    .external_reset_pin_i(misc[3]), .independent_watchdog_rst_i(misc[4]),
    .wakeup_pin_i(misc[0]), .rtc_alarm_i(misc[1]), .usb_wake_i(misc[2]), .boot_pins_i,
    .gpio_i, .gpio_pulse_i, .line_sel_i, .line_cfg_i, .pend_clr_i, .clk_sel_i,
    .efo_fail_i(misc[5]), .efo_fail_clr_i, .sleep_req_i, .stop_req_i, .stop_lp_reg_i,
    .standby_req_i, .periph_irq_i(misc[8]), .core_rst_o, .boot_sel_o, .cpu_clk_src_o,
    .efo_fail_irq_o, .supply_det_irq_o, .reg_mode_o, .clk_ctl_o, .rtc_wdg_run_o,
    .line_pend_o, .line_req_o, .state_o);

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    conclude();
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wait_st(input pwr_pkg::pwr_state_t s, input int n);
    for (int k = 0; k < n; k++) begin
      if (state_o === s) break;
      @(posedge clk_i);
      #1;
    end
    check("state", state_o, s);
  endtask : wait_st
  // Mode request pulse, state checked one edge later
  task automatic enter(input int m, input pwr_pkg::pwr_state_t s);
    @(posedge clk_i);
    {sleep_req_i, stop_req_i, standby_req_i} <= {m == 0, m == 1, m == 2};
    @(posedge clk_i);
    {sleep_req_i, stop_req_i, standby_req_i} <= 3'h0;
    #1;
    check("mode", state_o, s);
    @(posedge clk_i);
    #1;
  endtask : enter
  task automatic clr_pend();
    @(posedge clk_i);
    pend_clr_i <= 19'h7FFFF;
    @(posedge clk_i);
    pend_clr_i <= 19'h00000;
  endtask : clr_pend
  // Reset with given straps, three cycles long
  task automatic do_reset(input logic [1:0] b);
    far.set_boot(b);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check("rst_state", state_o, pwr_pkg::PWR_ST_RESET);
    check("rst_core", core_rst_o, 1'b1);
    check("rst_ctl", clk_ctl_o, 6'h35);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    wait_st(pwr_pkg::PWR_ST_RUN, 3);
    check("boot", boot_sel_o, b[0] ? (b[1] ? 2'h3 : 2'h1) : 2'h0);
    check("clk_src", cpu_clk_src_o, 2'h0);
    check("reg", reg_mode_o, pwr_pkg::PWR_REG_MAIN);
    check("core_rst", core_rst_o, 1'b0);
  endtask : do_reset
  task automatic conclude();
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    {supply_det_en_i, supply_det_fall_en_i, supply_det_rise_en_i, efo_fail_clr_i} = 4'h0;
    {sleep_req_i, stop_req_i, stop_lp_reg_i, standby_req_i} = 4'h0;
    line_sel_i = 112'h0;
    line_cfg_i = '{rise: 19'h0, fall: 19'h0, mask: 19'h7FFFF};
    pend_clr_i = 19'h0;
    clk_sel_i = 2'h0;
    do_reset(2'h0);
    // Random edge, mask and narrow-pulse trials on external lines
    for (int i = 0; i < 24; i++) begin
      ln = int'(xs() % 16);
      pin = int'(xs() % 80);
      md = int'(xs() % 4);
      msk = (xs() % 4) == 0;
      usep = (xs() % 3) == 0 && md != 0;
      @(posedge clk_i);
      line_sel_i[ln*7 +: 7] <= 7'(pin);
      line_cfg_i <= '{rise: 19'(md & 1) << ln, fall: 19'(md >> 1) << ln,
        mask: ~(19'h1 << ln) | (19'(msk) << ln)};
      clr_pend();
      lvl = gpio_i[pin];
      expv = 19'(!msk && (usep || (lvl ? md >> 1 : md & 1))) << ln;
      if (usep) far.pulse_pin(pin);
      else far.set_pin(pin, !lvl);
      #1;
      check("line_req", line_req_o, expv);
      @(posedge clk_i);
      far.clr_pulse();
      #1;
      check("line_pend", line_pend_o, expv);
    end
    // Stop, woken by an external line, the alarm line and the USB line
    @(posedge clk_i);
    line_sel_i[6:0] <= 7'h05;
    line_cfg_i <= '{rise: 19'h60001, fall: 19'h0, mask: 19'h1FFFE};
    far.set_pin(5, 1'b0);
    clr_pend();
    for (int k = 0; k < 3; k++) begin
      stop_lp_reg_i <= k[0];
      enter(1, pwr_pkg::PWR_ST_STOP);
      check("stop_ctl", clk_ctl_o, 6'h01);
      check("stop_reg", reg_mode_o, k[0] ? pwr_pkg::PWR_REG_LOW : pwr_pkg::PWR_REG_MAIN);
      if (k == 0) far.set_pin(5, 1'b1);
      else far.set_misc(k, 1'b1);
      #1;
      check("wake_req", line_req_o, 19'h1 << (k == 0 ? 0 : 16 + k));
      @(posedge clk_i);
      #1;
      check("wake", state_o, pwr_pkg::PWR_ST_RUN);
      if (k == 0) far.set_pin(5, 1'b0);
      else far.set_misc(k, 1'b0);
      clr_pend();
    end
    // Sleep: only the CPU clock stops, a peripheral interrupt wakes
    enter(0, pwr_pkg::PWR_ST_SLEEP);
    check("sleep_ctl", {clk_ctl_o.cpu_clk_en, clk_ctl_o.core_clk_en}, 2'h1);
    far.set_misc(8, 1'b1);
    #1;
    wait_st(pwr_pkg::PWR_ST_RUN, 2);
    far.set_misc(8, 1'b0);
    // Standby with each of the four exit causes, slow far side
    far.lag = 1;
    foreach (cause[c]) begin
      enter(2, pwr_pkg::PWR_ST_STANDBY);
      check("stby_reg", reg_mode_o, pwr_pkg::PWR_REG_OFF);
      check("stby_osc", {clk_ctl_o.pll_en, clk_ctl_o.ifo_en, clk_ctl_o.efo_en}, 3'h0);
      check("rtc_run", rtc_wdg_run_o, 1'b1);
      far.set_misc(2, 1'b1);
      repeat (3) @(posedge clk_i);
      #1;
      check("no_wake", state_o, pwr_pkg::PWR_ST_STANDBY);
      far.set_misc(2, 1'b0);
      far.set_misc(cause[c], 1'b1);
      #1;
      wait_st(pwr_pkg::PWR_ST_RESET, 3);
      far.set_misc(cause[c], 1'b0);
      #1;
      wait_st(pwr_pkg::PWR_ST_RUN, 4);
      check("restart_src", cpu_clk_src_o, 2'h0);
    end
    far.lag = 0;
    clr_pend();
    // PLL selection, then external clock failure
    clk_sel_i <= 2'h2;
    repeat (3) @(posedge clk_i);
    #1;
    check("pll_sel", {cpu_clk_src_o, clk_ctl_o.pll_en}, 3'h5);
    @(posedge clk_i);
    clk_sel_i <= 2'h1;
    repeat (3) @(posedge clk_i);
    #1;
    check("efo_sel", cpu_clk_src_o, 2'h1);
    far.set_misc(5, 1'b1);
    repeat (3) @(posedge clk_i);
    #1;
    check("efo_irq", efo_fail_irq_o, 1'b1);
    check("efo_off", {cpu_clk_src_o, clk_ctl_o.efo_en}, 3'h0);
    far.set_misc(5, 1'b0);
    repeat (2) @(posedge clk_i);
    #1;
    check("efo_hold", efo_fail_irq_o, 1'b1);
    @(posedge clk_i);
    efo_fail_clr_i <= 1'b1;
    @(posedge clk_i);
    efo_fail_clr_i <= 1'b0;
    clk_sel_i <= 2'h0;
    @(posedge clk_i);
    #1;
    check("efo_clr", efo_fail_irq_o, 1'b0);
    // Supply detector table: enable, fall, rise, level, pulses
    foreach (sup_tab[t]) begin
      @(posedge clk_i);
      {supply_det_en_i, supply_det_fall_en_i, supply_det_rise_en_i} <= sup_tab[t][4:2];
      far.set_misc(7, sup_tab[t][1]);
      cnt = 0;
      repeat (4) begin
        @(posedge clk_i);
        #1;
        if (supply_det_irq_o !== 1'b0) cnt++;
      end
      check("sup_irq", cnt, {31'h0, sup_tab[t][0]});
    end
    // Supply under reset threshold
    far.set_misc(6, 1'b1);
    #1;
    wait_st(pwr_pkg::PWR_ST_RESET, 3);
    repeat (3) @(posedge clk_i);
    #1;
    check("low_hold", core_rst_o, 1'b1);
    far.set_misc(6, 1'b0);
    #1;
    wait_st(pwr_pkg::PWR_ST_RUN, 3);
    // Every strap code
    for (int b = 0; b < 4; b++) do_reset(2'(b));
    conclude();
  end
endmodule : test_power_modes_and_wake_events
`default_nettype wire
